// File: dv/dtc_pins_model.sv
`timescale 1ns/100ps
// ============================================================
// Board side of the event pin: pulses only on request
module dtc_pins_model (
    // Clock
    input wire logic sys_clk,
    // Burst request from the bench
    input wire logic burst_go,
    input wire logic [7:0] burst_len,
    // Event pin and status
    output logic event_input_two,
    output logic busy
);
    // Phase of 3 to 6 clocks, so both quick and slow edges are seen
    task automatic wait_phase();
        repeat (3 + $urandom % 4) @(posedge sys_clk);
    endtask

    // Line idles low between bursts, as a pulled-down net would
    initial begin
        event_input_two = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (burst_go) begin
                busy <= 1'b1;
                repeat (burst_len) begin
                    wait_phase();
                    event_input_two <= 1'b1;
                    wait_phase();
                    event_input_two <= 1'b0;
                end
                repeat (5) @(posedge sys_clk);
                busy <= 1'b0;
            end
        end
    end
endmodule // dtc_pins_model

// File: dv/dtc_timer_monitor.sv
`timescale 1ns/100ps
// ============================================================
// Port checks for the dual timer/event counter
module dtc_timer_monitor
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Controls
    input wire dtc_ctrl_t mode_control_one,
    input wire dtc_ctrl_t mode_control_two,
    input wire logic cascade_select,
    // Results
    input wire logic [7:0] counter_one,
    input wire logic [7:0] counter_two,
    input wire logic match_irq_one,
    input wire logic timer_output_one,
    input wire logic timer_output_one_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // Steps of multi-cycle behaviours
    sequence pwm_stop_one;
        mode_control_one.pwm_mode_select &&
            $fell(mode_control_one.count_enable);
    endsequence
    sequence set_req_one;
        mode_control_one.output_set_request &&
            !mode_control_one.output_clear_request &&
            !mode_control_one.pwm_mode_select &&
            mode_control_one.output_enable && timer_output_one_oe;
    endsequence

    // ============================================================
    // Assertions
    chk_irq_one_pulse: assert property (
        match_irq_one |=> !match_irq_one) else $error("irq one too long");
    chk_irq_clears_one: assert property (
        match_irq_one |-> counter_one == 8'h00)
        else $error("counter one not cleared at match");
    chk_chain_clears: assert property (
        match_irq_one && cascade_select |-> counter_two == 8'h00)
        else $error("counter two not cleared at chain match");
    chk_count_step: assert property (
        $changed(counter_one) |-> counter_one == 8'h00 ||
            counter_one == $past(counter_one) + 8'h01)
        else $error("counter one jumped");
    chk_stop_zero: assert property (
        !mode_control_one.count_enable &&
            (!cascade_select || !mode_control_two.count_enable)
        |=> counter_one == 8'h00) else $error("stopped counter not zero");
    chk_pwm_no_irq: assert property (
        mode_control_one.pwm_mode_select &&
            $past(mode_control_one.pwm_mode_select) |-> !match_irq_one)
        else $error("irq in pwm mode");
    chk_oe_follow: assert property (
        1'b1 |=> timer_output_one_oe == $past(mode_control_one.output_enable))
        else $error("output enable not following control");
    // Level register, then pin register: the pin shows it two edges on
    chk_set_level: assert property (
        set_req_one ##1 mode_control_one.output_enable |=> timer_output_one)
        else $error("set request ignored");
    chk_pwm_stop: assert property (
        pwm_stop_one ##1 mode_control_one.pwm_mode_select[*2] |=>
            timer_output_one == (timer_output_one_oe &&
            mode_control_one.invert_or_polarity_select))
        else $error("pwm output active after stop");
endmodule // dtc_timer_monitor

bind dtc_timer dtc_timer_monitor MON (.sys_clk, .rst_n, .mode_control_one,
    .mode_control_two, .cascade_select, .counter_one, .counter_two,
    .match_irq_one, .timer_output_one, .timer_output_one_oe);

// File: dv/test_dual_8bit_timer_event_counter.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
// ============================================================
// Self-checking bench for the dual timer/event counter
module test_dual_8bit_timer_event_counter;
    import dtc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    dtc_ctrl_t c1 = '0;
    dtc_ctrl_t c2 = '0;
    logic casc = 1'b0;
    logic cw1 = 1'b0;
    logic cw2 = 1'b0;
    logic rd1 = 1'b0;
    logic go = 1'b0;
    logic [7:0] cv1 = 8'h00;
    logic [7:0] cv2 = 8'h00;
    logic [7:0] len = 8'h00;
    logic [7:0] cmp;
    logic [7:0] cnt1;
    logic [7:0] cnt2;
    logic irq1, irq2, to1, oe1, ev2, busy, lvl;
    logic to2, oe2;
    int errors = 0;
    int comparisons = 0;
    int irq2_n = 0;
    int gap, n, n0;
    int exp_q[$];

    always #25 sys_clk = ~sys_clk;

    // Second interrupt is only counted, it is never waited on
    always @(posedge sys_clk) if (irq2 === 1'b1) irq2_n++;

    dtc_timer DUT (.sys_clk, .rst_n, .mode_control_one(c1),
        .mode_control_two(c2), .cascade_select(casc), .compare_one(cv1),
        .compare_write_one(cw1), .compare_two(cv2), .compare_write_two(cw2),
        .counter_read_one(rd1), .counter_read_two(1'b0),
        .event_input_one(1'b0), .event_input_two(ev2), .counter_one(cnt1),
        .counter_two(cnt2), .match_irq_one(irq1), .match_irq_two(irq2),
        .timer_output_one(to1), .timer_output_one_oe(oe1),
        .timer_output_two(to2), .timer_output_two_oe(oe2));
    dtc_pins_model PINS (.sys_clk, .burst_go(go), .burst_len(len),
        .event_input_two(ev2), .busy);

    // ============================================================
    // Bench tasks
    task automatic step(int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task automatic done(string s);
        $display("Test done: %s", s);
    endtask
    task automatic load(logic [7:0] a, logic [7:0] b);
        cv1 = a;
        cv2 = b;
        cw1 = 1'b1;
        cw2 = 1'b1;
        step(1);
        cw1 = 1'b0;
        cw2 = 1'b0;
    endtask
    // Bounded wait for the first timer's match pulse
    task automatic wait_irq();
        gap = 0;
        do begin
            step(1);
            gap++;
        end while (irq1 !== 1'b1 && gap < 5000);
    endtask
    task automatic burst(logic [7:0] k);
        len = k;
        go = 1'b1;
        step(1);
        go = 1'b0;
        n = 0;
        do begin
            step(1);
            n++;
        end while (busy && n < 2000);
    endtask
    task automatic run_interval(logic [2:0] code, logic [7:0] m);
        int div;
        div = (code < 3'h6) ? (1 << code) : (code == 3'h6 ? 128 : 512);
        exp_q.push_back((m + 1) * div);
        c1 = '0;
        c1.prescaler_select = code;
        load(m, 8'h00);
        c1.count_enable = 1'b1;
        wait_irq();
        wait_irq();
        `CHK("interval", exp_q.pop_front(), gap)
        c1.count_enable = 1'b0;
        step(2);
        `CHK("stop clear", 8'h00, cnt1)
        done("interval");
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // Watchdog, well above the expected run length
    initial begin
        #5000000;
        errors++;
        print_verdict();
    end

    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(12));
        step(2);
        rst_n = 1'b1;
        run_interval(3'h2, 8'h00);
        run_interval(3'h2, 8'hff);
        for (int k = 2; k < 8; k++) begin
            run_interval(k[2:0], 8'($urandom % (k < 6 ? 64 : 4)));
        end
        // Event counting on both edge codes
        for (int k = 0; k < 2; k++) begin
            c2 = '0;
            c2.prescaler_select = k[2:0];
            load(8'h00, 8'h05);
            c2.count_enable = 1'b1;
            n0 = irq2_n;
            burst(8'h03);
            `CHK("events", 8'h03, cnt2)
            burst(8'h03);
            `CHK("event irq", n0 + 1, irq2_n)
            `CHK("event clear", 8'h00, cnt2)
            c2.count_enable = 1'b0;
            done("event");
        end
        // Second pin: software level and its drive enable
        c2.output_enable = 1'b1;
        c2.output_set_request = 1'b1;
        step(1);
        c2.output_set_request = 1'b0;
        step(2);
        `CHK("set level two", 2'b11, {oe2, to2})
        c2 = '0;
        done("pin two");
        // Software levels, then square wave, then pin gating
        c1 = '0;
        c1.output_enable = 1'b1;
        c1.output_set_request = 1'b1;
        step(1);
        c1.output_set_request = 1'b0;
        step(2);
        `CHK("set level", 1'b1, to1)
        c1.output_clear_request = 1'b1;
        step(1);
        c1.output_clear_request = 1'b0;
        step(2);
        `CHK("clear level", 1'b0, to1)
        c1.invert_or_polarity_select = 1'b1;
        c1.prescaler_select = 3'h2;
        load(8'h03, 8'h00);
        c1.count_enable = 1'b1;
        wait_irq();
        lvl = to1;
        wait_irq();
        `CHK("toggle", ~lvl, to1)
        `CHK("half period", 16, gap)
        c1.output_enable = 1'b0;
        step(2);
        `CHK("gated pin", 1'b0, to1)
        c1.count_enable = 1'b0;
        done("square");
        // PWM: idle until overflow, width from compare, stop
        c1 = '0;
        c1.pwm_mode_select = 1'b1;
        c1.output_enable = 1'b1;
        c1.prescaler_select = 3'h2;
        cmp = 8'($urandom % 32);
        load(cmp, 8'h00);
        c1.count_enable = 1'b1;
        n = 0;
        while (to1 !== 1'b1 && n < 5000) begin
            step(1);
            n++;
        end
        `CHK("pwm idle", 1'b1, n >= 1020)
        n = 0;
        while (to1 === 1'b1 && n < 5000) begin
            step(1);
            n++;
        end
        `CHK("pwm width", (cmp + 1) * 4, n)
        c1.count_enable = 1'b0;
        step(4);
        `CHK("pwm stop", 1'b0, to1)
        c1.invert_or_polarity_select = 1'b1;
        step(3);
        `CHK("pwm active low", 1'b1, to1)
        done("pwm");
        // Cascade: second prescaler set far off to show it is ignored
        c1 = '0;
        c2 = '0;
        casc = 1'b1;
        c1.prescaler_select = 3'h2;
        c2.prescaler_select = 3'h7;
        cmp = 8'($urandom);
        load(cmp, 8'h01);
        c2.count_enable = 1'b1;
        step(1);
        c1.count_enable = 1'b1;
        n0 = irq2_n;
        wait_irq();
        wait_irq();
        `CHK("chain period", (cmp + 257) * 4, gap)
        `CHK("chain irq two", 1'b1, irq2_n > n0)
        step(40);
        c1.count_enable = 1'b0;
        step(2);
        n = {cnt2, cnt1};
        step(20);
        `CHK("chain hold", n, {cnt2, cnt1})
        c2.count_enable = 1'b0;
        step(2);
        `CHK("chain clear", 16'h0000, {cnt2, cnt1})
        casc = 1'b0;
        done("cascade");
        // Read pause, then a compare below the running count
        c1 = '0;
        c1.prescaler_select = 3'h2;
        load(8'hff, 8'h00);
        c1.count_enable = 1'b1;
        step(60);
        rd1 = 1'b1;
        step(1);
        cmp = cnt1;
        step(12);
        `CHK("read pause", cmp, cnt1)
        rd1 = 1'b0;
        step(8);
        `CHK("read resume", 1'b1, cnt1 !== cmp)
        cmp = cnt1;
        load(8'h05, 8'h00);
        wait_irq();
        `CHK("wrap first", 1'b1, gap > (250 - cmp) * 4)
        c1.count_enable = 1'b0;
        done("read and wrap");
        print_verdict();
    end
endmodule // test_dual_8bit_timer_event_counter

// File: hdl/dtc_tick_gen.sv
`timescale 1ns/100ps
// ============================================================
// Count clock source: external edge or internal divider
module dtc_tick_gen
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Selection and control
    input wire logic [2:0] clock_select,
    input wire logic run,
    input wire logic read_hold,
    // Pin
    input wire logic event_input,
    // Count pulse
    output logic tick
);

    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic pend_reg;
    logic [8:0] div_reg;
    logic [8:0] mask;
    logic rise;
    logic fall;
    logic raw;

    // Two-stage synchroniser, then a delayed copy for edges
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= event_input;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~prev_reg;
    assign fall = ~sync2_reg & prev_reg;

    // Divider held at zero while stopped, so no stray tick
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            div_reg <= DIV_ZERO;
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    // Code decode for the count source
    assign mask = (clock_select == SEL_DIV4) ? MASK_DIV4 :
                  (clock_select == SEL_DIV8) ? MASK_DIV8 :
                  (clock_select == SEL_DIV16) ? MASK_DIV16 :
                  (clock_select == SEL_DIV32) ? MASK_DIV32 :
                  (clock_select == SEL_DIV128) ? MASK_DIV128 :
                  MASK_DIV512;
    assign raw = (clock_select == SEL_FALL) ? fall :
                 (clock_select == SEL_RISE) ? rise :
                 ((div_reg & mask) == mask);

    // Only one pulse landing during a read is held back; the rest are lost
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !run) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= read_hold & (raw | pend_reg);
        end
    end

    assign tick = run & ~read_hold & (raw | pend_reg);

endmodule // dtc_tick_gen

// File: hdl/dtc_timer.sv
`timescale 1ns/100ps
// ============================================================
module dtc_timer
    import dtc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control words
    input wire dtc_ctrl_t mode_control_one,
    input wire dtc_ctrl_t mode_control_two,
    input wire logic cascade_select,
    // Compare writes
    input wire logic [7:0] compare_one,
    input wire logic compare_write_one,
    input wire logic [7:0] compare_two,
    input wire logic compare_write_two,
    // Counter read strobes
    input wire logic counter_read_one,
    input wire logic counter_read_two,
    // Event pins
    input wire logic event_input_one,
    input wire logic event_input_two,
    // Counter values
    output logic [7:0] counter_one,
    output logic [7:0] counter_two,
    // Match interrupts
    output logic match_irq_one,
    output logic match_irq_two,
    // Timer output pins
    output logic timer_output_one,
    output logic timer_output_one_oe,
    output logic timer_output_two,
    output logic timer_output_two_oe
);

    // ============================================================
    // Per-channel views of the ports
    dtc_ctrl_t ctrl [2];
    logic [7:0] cmp_wdata [2];
    logic cmp_write [2];
    logic read_req [2];
    logic event_pin [2];
    logic [7:0] cnt_w [2];
    logic irq_w [2];
    logic pin_w [2];
    logic oe_w [2];
    logic tick_w [2];
    logic run_w [2];

    assign ctrl[0] = mode_control_one;
    assign ctrl[1] = mode_control_two;
    assign cmp_wdata[0] = compare_one;
    assign cmp_wdata[1] = compare_two;
    assign cmp_write[0] = compare_write_one;
    assign cmp_write[1] = compare_write_two;
    assign read_req[0] = counter_read_one;
    assign read_req[1] = counter_read_two;
    assign event_pin[0] = event_input_one;
    assign event_pin[1] = event_input_two;

    assign counter_one = cnt_w[0];
    assign counter_two = cnt_w[1];
    assign match_irq_one = irq_w[0];
    assign match_irq_two = irq_w[1];
    assign timer_output_one = pin_w[0];
    assign timer_output_two = pin_w[1];
    assign timer_output_one_oe = oe_w[0];
    assign timer_output_two_oe = oe_w[1];

    // ============================================================
    // Cascade terms shared by both channels
    logic casc;
    logic low_full;
    logic full_match;
    logic both_off;
    logic [7:0] cmp_cur [2];

    assign casc = cascade_select;
    // Low byte about to carry into the high byte
    assign low_full = (cnt_w[0] == CNT_TOP);
    // Both bytes equal their compares in the same tick
    assign full_match = casc && (cnt_w[0] == cmp_cur[0]) &&
                        (cnt_w[1] == cmp_cur[1]);
    // The chain is only zeroed when both enables are low
    assign both_off = !ctrl[0].count_enable && !ctrl[1].count_enable;

    // ============================================================
    // One counter, compare and output stage per channel
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            logic [7:0] cnt_reg;
            logic [7:0] cnt_next;
            logic [7:0] cmp_reg;
            logic [7:0] cmp_act_reg;
            logic irq_reg;
            logic lvl_reg;
            logic pin_reg;
            logic oe_reg;
            dtc_pwm_state_t pwm_reg;
            dtc_pwm_state_t pwm_next;
            logic pwm;
            logic run;
            logic zero;
            logic step;
            logic inc;
            logic hit;
            logic clr;
            logic ovf;
            logic irq_ev;
            logic pwm_level;
            logic wave;

            // Second channel follows the first enable in cascade
            assign run = (casc && i == 1) ? ctrl[0].count_enable
                                          : ctrl[i].count_enable;
            assign run_w[i] = run;
            // Counter forced to zero while its enable is low; in cascade only while both are
            assign zero = (casc && i == 1) ? both_off
                        : (casc ? both_off : !ctrl[i].count_enable);
            // PWM is an individual-mode feature only
            assign pwm = ctrl[i].pwm_mode_select && !casc;

            // Count pulse: chained channels share the first source
            assign step = casc ? tick_w[0] : tick_w[i];
            assign inc = (casc && i == 1) ? low_full : 1'b1;
            assign hit = (cnt_reg == cmp_cur[i]);
            assign clr = casc ? full_match : (hit && !pwm);
            assign ovf = (cnt_reg == CNT_TOP);

            // Match interrupt, never in PWM; high byte keeps its own
            assign irq_ev = step && (casc ? ((i == 0) ? full_match
                        : (hit && (full_match || low_full)))
                        : (hit && !pwm));

            // Next count; a compare below the count wraps first
            assign cnt_next = zero ? CNT_ZERO
                : !(step && run) ? cnt_reg
                : clr ? CNT_ZERO
                : inc ? 8'(cnt_reg + 8'h01)
                : cnt_reg;

            // Compare in use: PWM takes the shadow copy
            assign cmp_cur[i] = pwm ? cmp_act_reg : cmp_reg;

            // Compare register and its PWM shadow
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cmp_reg <= CMP_RESET;
                    cmp_act_reg <= CMP_RESET;
                end else begin
                    if (cmp_write[i]) begin
                        cmp_reg <= cmp_wdata[i];
                    end
                    if (!pwm || !run || (step && ovf)) begin
                        cmp_act_reg <= cmp_reg;
                    end
                end
            end

            // Counter and interrupt pulse
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cnt_reg <= CNT_ZERO;
                    irq_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_next;
                    irq_reg <= irq_ev && run && !zero;
                end
            end

            // PWM phase: wait for overflow, active up to the match
            always_comb begin
                pwm_next = pwm_reg;
                if (!pwm || !run) begin
                    pwm_next = PWM_WAIT;
                end else if (step) begin
                    case (pwm_reg)
                        PWM_WAIT: begin
                            if (ovf) begin
                                pwm_next = PWM_ACTIVE;
                            end
                        end
                        PWM_ACTIVE: begin
                            if (hit && !ovf) begin
                                pwm_next = PWM_INACTIVE;
                            end
                        end
                        PWM_INACTIVE: begin
                            if (ovf) begin
                                pwm_next = PWM_ACTIVE;
                            end
                        end
                        default: begin
                            pwm_next = PWM_WAIT;
                        end
                    endcase
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    pwm_reg <= PWM_WAIT;
                end else begin
                    pwm_reg <= pwm_next;
                end
            end

            // Active level inverted when low-active polarity chosen
            assign pwm_level = (pwm_reg == PWM_ACTIVE) ^
                               ctrl[i].invert_or_polarity_select;

            // Software level; a lone set or clear request takes priority over toggling
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    lvl_reg <= 1'b0;
                end else if (ctrl[i].output_set_request &&
                             !ctrl[i].output_clear_request) begin
                    lvl_reg <= 1'b1;
                end else if (!ctrl[i].output_set_request &&
                             ctrl[i].output_clear_request) begin
                    lvl_reg <= 1'b0;
                end else if (irq_ev && run && !zero &&
                             ctrl[i].invert_or_polarity_select) begin
                    lvl_reg <= !lvl_reg;
                end
            end

            // Waveform choice between PWM and toggle level
            assign wave = pwm ? pwm_level : lvl_reg;

            // Pin stage: disabled output is not driven
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    pin_reg <= 1'b0;
                    oe_reg <= 1'b0;
                end else begin
                    pin_reg <= ctrl[i].output_enable & wave;
                    oe_reg <= ctrl[i].output_enable;
                end
            end

            assign cnt_w[i] = cnt_reg;
            assign irq_w[i] = irq_reg;
            assign pin_w[i] = pin_reg;
            assign oe_w[i] = oe_reg;
        end
    endgenerate

    // ============================================================
    // Count clock sources; a read stalls the chain as a whole
    logic hold_one;
    logic hold_two;

    assign hold_one = counter_read_one || (casc && counter_read_two);
    assign hold_two = counter_read_two;

    dtc_tick_gen u_tick_one (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clock_select(ctrl[0].prescaler_select),
        .run(run_w[0]),
        .read_hold(hold_one),
        .event_input(event_pin[0]),
        .tick(tick_w[0])
    );

    // Second source stays stopped in cascade, its setting unused
    dtc_tick_gen u_tick_two (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clock_select(ctrl[1].prescaler_select),
        .run(run_w[1] && !casc),
        .read_hold(hold_two),
        .event_input(event_pin[1]),
        .tick(tick_w[1])
    );

    // Divider restarts from zero on enable, so the first tick
    // may come up to one count period late.

endmodule // dtc_timer

// File: shared/dtc_pkg.sv
// ============================================================
// Shared constants and types for the dual timer/event counter
package dtc_pkg;

    // ============================================================
    // Counter widths and values
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [7:0] CMP_RESET = 8'h00;

    // ============================================================
    // Count clock selection codes
    localparam logic [2:0] SEL_FALL = 3'h0;
    localparam logic [2:0] SEL_RISE = 3'h1;
    localparam logic [2:0] SEL_DIV4 = 3'h2;
    localparam logic [2:0] SEL_DIV8 = 3'h3;
    localparam logic [2:0] SEL_DIV16 = 3'h4;
    localparam logic [2:0] SEL_DIV32 = 3'h5;
    localparam logic [2:0] SEL_DIV128 = 3'h6;
    localparam logic [2:0] SEL_DIV512 = 3'h7;

    // ============================================================
    // Divider: a tick falls when all masked low bits are ones
    localparam int DIV_W = 9;
    localparam logic [8:0] DIV_ZERO = 9'h000;
    localparam logic [8:0] DIV_ONE = 9'h001;
    localparam logic [8:0] MASK_DIV4 = 9'h003;
    localparam logic [8:0] MASK_DIV8 = 9'h007;
    localparam logic [8:0] MASK_DIV16 = 9'h00f;
    localparam logic [8:0] MASK_DIV32 = 9'h01f;
    localparam logic [8:0] MASK_DIV128 = 9'h07f;
    localparam logic [8:0] MASK_DIV512 = 9'h1ff;

    // ============================================================
    // Per-timer control word
    typedef struct packed {
        logic count_enable;
        logic pwm_mode_select;
        logic invert_or_polarity_select;
        logic output_enable;
        logic output_set_request;
        logic output_clear_request;
        logic [2:0] prescaler_select;
    } dtc_ctrl_t;

    // PWM waveform phase
    typedef enum logic [1:0] {
        PWM_WAIT = 2'b00,
        PWM_ACTIVE = 2'b01,
        PWM_INACTIVE = 2'b10
    } dtc_pwm_state_t;

endpackage
